// >>> include/eth_filt_consts.svh
// register map, field positions and limits of the receive filter
`ifndef ETH_FILT_CONSTS_SVH
`define ETH_FILT_CONSTS_SVH

// register byte offsets on the 12-bit register bus
`define EF_OFF_NET_CFG 12'h004
`define EF_OFF_RX_STAT 12'h008
`define EF_OFF_HASH_LO 12'h080
`define EF_OFF_HASH_HI 12'h084
`define EF_OFF_SA1_LO 12'h088
`define EF_OFF_SA1_HI 12'h08c
`define EF_OFF_TID1 12'h0a8
`define EF_OFF_TX_512 12'h128

// network configuration bit positions
`define EF_CFG_COPY_ALL 4
`define EF_CFG_MC_HASH 6
`define EF_CFG_UC_HASH 7
`define EF_CFG_NO_PAUSE 23
`define EF_CFG_KEEP_FCS 26

// type id match enable bit
`define EF_TID_EN 31

// reset value of every writable register and of the counter
`define EF_RST_WORD 32'h0000_0000

// frame layout and length window of the counter
`define EF_HDR_BYTES 4'he
`define EF_DA_BYTES 4'h6
`define EF_TYPE_HI 4'hc
`define EF_TYPE_LO 4'hd
`define EF_PAUSE_TYPE 16'h8808
`define EF_LEN_MIN 14'h0200
`define EF_LEN_MAX 14'h03ff

// bus answers
`define EF_RESP_OKAY 2'h0
`define EF_RESP_SLVERR 2'h2

// buffer shape: byte plus end-of-frame flag, four entries
`define EF_FIFO_W 9
`define EF_FIFO_DEPTH 4

`endif

// >>> include/eth_filt_pkg.sv
// types shared by the receive filter modules
package eth_filt_pkg;

  // receive walk: waiting for a first byte, or inside a frame
  typedef enum logic {RX_IDLE, RX_FRAME} rx_state_t;

  // whole state of the filter top
  typedef struct packed {
    rx_state_t rx_st;
    logic [3:0] byte_cnt;
    logic [47:0] da;
    logic [15:0] etype;
    logic err_seen;
    logic rxer_meta;
    logic rxer_sync;
    logic [31:0] cfg;
    logic [31:0] hash_lo;
    logic [31:0] hash_hi;
    logic [31:0] sa_lo;
    logic [31:0] sa_hi;
    logic [31:0] tid;
    logic [31:0] tx_cnt;
    logic done;
    logic copy;
    logic mc_hit;
    logic uc_hit;
    logic pause_drop;
    logic [5:0] last_idx;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } filt_state_t;

endpackage

// >>> include/byte_fifo_if.sv
// valid/ready carrier between the filter and its frame buffer
`timescale 1ns/1ps
interface byte_fifo_if #(parameter int W = 9);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

// >>> verilog/stream_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // both sides
  byte_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic push;
  logic pop;

  // full and empty straight from the count, so the source really stalls
  assign port.push_ready = (q.cnt != (AW+1)'(DEPTH));
  assign port.pop_valid = (q.cnt != '0);
  assign port.pop_data = q.mem[q.rd];
  assign push = port.push_valid & port.push_ready;
  assign pop = port.pop_valid & port.pop_ready;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = port.push_data;
      d.wr = q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = q.rd + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // stream_fifo

// >>> verilog/hash_lookup.sv
// 6-bit address hash and its lookup in the 64-bit table
`timescale 1ns/1ps
module hash_lookup (
  // inputs
  input wire logic [47:0] da_i,
  input wire logic [63:0] table_i,
  // results
  output logic [5:0] idx_o,
  output logic hit_o
);
  // one index bit folds every sixth address bit
  for (genvar n = 0; n < 6; n++) begin : g_fold
    assign idx_o[n] = da_i[n] ^ da_i[n+6] ^ da_i[n+12] ^ da_i[n+18]
                    ^ da_i[n+24] ^ da_i[n+30] ^ da_i[n+36] ^ da_i[n+42];
  end

  // bottom word holds bits 0 to 31, top word 32 to 63
  assign hit_o = table_i[idx_o];
endmodule // hash_lookup

// >>> verilog/eth_rx_address_filter.sv
// receive address filter with hash table, copy-all and a tx size counter
//
// Functional notes
// - hash table is 64 bits, bottom word low half, top word high half
// - hash bit n is XOR of address bits n, n+6 up to n+42
// - address bit 0 is lsb of first byte, bit 47 msb of last
// - multicast hit needs multicast enable, address bit 0 one, table bit set
// - unicast hit needs unicast enable, address bit 0 zero, table bit set
// - copy-all keeps every frame except long, short, bad fcs or rx error
// - bad fcs frames are still kept when config bit 26 is set
// - config bit 23 drops pause frames over every other match
// - read-only 32-bit count of sent 512 to 1023 byte frames, zero at reset
// - count only frames sent without underrun and within retry limit
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "eth_filt_consts.svh"
module eth_rx_address_filter (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,

  // receive byte stream from the mac receive path
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  input wire logic rx_too_long_i,
  input wire logic rx_too_short_i,
  input wire logic rx_fcs_bad_i,
  output logic rx_ready_o,

  // receive error pin from the phy
  input wire logic receive_error_input_i,

  // frame bytes towards memory
  output logic mem_valid_o,
  output logic [7:0] mem_data_o,
  output logic mem_last_o,
  input wire logic mem_ready_i,

  // per-frame verdict
  output logic frame_done_o,
  output logic frame_copy_o,
  output logic frame_mc_hit_o,
  output logic frame_uc_hit_o,

  // transmit completion report
  input wire logic tx_done_i,
  input wire logic [13:0] tx_len_i,
  input wire logic tx_underrun_i,
  input wire logic tx_retry_limit_i,

  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,

  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  eth_filt_pkg::filt_state_t q;
  eth_filt_pkg::filt_state_t d;

  // address decode, shared by the read and the write side
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `EF_OFF_NET_CFG,
      `EF_OFF_RX_STAT,
      `EF_OFF_HASH_LO,
      `EF_OFF_HASH_HI,
      `EF_OFF_SA1_LO,
      `EF_OFF_SA1_HI,
      `EF_OFF_TID1,
      `EF_OFF_TX_512: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // merge a write under its byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // read word for an address; unmapped space reads zero
  function automatic logic [31:0] rd_word(input eth_filt_pkg::filt_state_t s,
                                          input logic [11:0] a);
    case (a)
      `EF_OFF_NET_CFG: rd_word = s.cfg;
      `EF_OFF_RX_STAT: rd_word = {18'h0, s.last_idx, 3'h0, s.pause_drop,
                                  s.uc_hit, s.mc_hit, s.copy, s.done};
      `EF_OFF_HASH_LO: rd_word = s.hash_lo;
      `EF_OFF_HASH_HI: rd_word = s.hash_hi;
      `EF_OFF_SA1_LO: rd_word = s.sa_lo;
      `EF_OFF_SA1_HI: rd_word = s.sa_hi;
      `EF_OFF_TID1: rd_word = s.tid;
      `EF_OFF_TX_512: rd_word = s.tx_cnt;
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction

  // frame buffer between the receive stream and memory
  byte_fifo_if #(.W(`EF_FIFO_W)) buf_if ();

  stream_fifo #(
    .W(`EF_FIFO_W),
    .DEPTH(`EF_FIFO_DEPTH)
  ) u_buf (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .port(buf_if.fifo)
  );

  // the receive side stalls whenever the buffer is full
  logic rx_take;
  assign rx_ready_o = buf_if.push_ready;
  assign rx_take = rx_valid_i & buf_if.push_ready;
  assign buf_if.push_valid = rx_valid_i;
  assign buf_if.push_data = {rx_last_i, rx_data_i};

  // memory side drains the buffer at its own pace
  assign mem_valid_o = buf_if.pop_valid;
  assign mem_data_o = buf_if.pop_data[7:0];
  assign mem_last_o = buf_if.pop_data[8];
  assign buf_if.pop_ready = mem_ready_i;

  // hash of the captured destination address
  logic [5:0] hash_idx;
  logic hash_bit;

  hash_lookup u_hash (
    .da_i(q.da),
    .table_i({q.hash_hi, q.hash_lo}),
    .idx_o(hash_idx),
    .hit_o(hash_bit)
  );

  // match terms, valid once the header is complete
  logic hdr_ok;
  logic mc_hit;
  logic uc_hit;
  logic sa_hit;
  logic tid_hit;
  logic is_pause;
  logic err_now;
  logic len_bad;
  logic fcs_drop;
  logic any_hit;
  logic keep;
  logic tx_counts;

  // short frames never complete the header, so their match terms are ignored
  assign hdr_ok = (q.rx_st == eth_filt_pkg::RX_FRAME) && (q.byte_cnt == `EF_HDR_BYTES);
  assign mc_hit = q.cfg[`EF_CFG_MC_HASH] & q.da[0] & hash_bit;
  assign uc_hit = q.cfg[`EF_CFG_UC_HASH] & ~q.da[0] & hash_bit;
  assign sa_hit = (q.da == {q.sa_hi[15:0], q.sa_lo});
  assign tid_hit = q.tid[`EF_TID_EN] & (q.etype == q.tid[15:0]);
  assign is_pause = (q.etype == `EF_PAUSE_TYPE);

  // error terms sampled with the last byte
  assign err_now = q.err_seen | q.rxer_sync;
  assign len_bad = rx_too_long_i | rx_too_short_i | ~hdr_ok;
  assign fcs_drop = rx_fcs_bad_i & ~q.cfg[`EF_CFG_KEEP_FCS];
  assign any_hit = q.cfg[`EF_CFG_COPY_ALL] | mc_hit | uc_hit | sa_hit | tid_hit;

  // pause suppression overrides every match, copy-all included
  assign keep = ~len_bad & ~err_now & ~fcs_drop & any_hit
              & ~(is_pause & q.cfg[`EF_CFG_NO_PAUSE]);

  // only clean transmissions inside the size window are counted
  assign tx_counts = tx_done_i & ~tx_underrun_i & ~tx_retry_limit_i
                   & (tx_len_i >= `EF_LEN_MIN) & (tx_len_i <= `EF_LEN_MAX);

  // registered outputs
  assign frame_done_o = q.done;
  assign frame_copy_o = q.copy;
  assign frame_mc_hit_o = q.mc_hit;
  assign frame_uc_hit_o = q.uc_hit;

  // bus handshake; a write waits for its response to be taken
  assign s_axi_awready = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready = ~q.w_got & ~q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // next state of the whole block
  always_comb begin
    d = q;
    d.done = 1'b0;

    // error pin crosses in through two flops
    d.rxer_meta = receive_error_input_i;
    d.rxer_sync = q.rxer_meta;

    // receive walk over the header bytes
    case (q.rx_st)
      eth_filt_pkg::RX_IDLE: begin
        if (rx_take) begin
          d.da[7:0] = rx_data_i;
          d.byte_cnt = 4'h1;
          d.err_seen = q.rxer_sync;
          if (!rx_last_i) begin
            d.rx_st = eth_filt_pkg::RX_FRAME;
          end else begin
            // a one-byte frame is a runt and is dropped
            d.done = 1'b1;
            d.copy = 1'b0;
            d.mc_hit = 1'b0;
            d.uc_hit = 1'b0;
            d.pause_drop = 1'b0;
          end
        end
      end
      eth_filt_pkg::RX_FRAME: begin
        // an error pulse anywhere in the frame marks it
        if (q.rxer_sync) begin
          d.err_seen = 1'b1;
        end
        if (rx_take) begin
          if (q.byte_cnt < `EF_DA_BYTES) begin
            d.da[{q.byte_cnt[2:0], 3'h0} +: 8] = rx_data_i;
          end
          if (q.byte_cnt == `EF_TYPE_HI) begin
            d.etype[15:8] = rx_data_i;
          end
          if (q.byte_cnt == `EF_TYPE_LO) begin
            d.etype[7:0] = rx_data_i;
          end
          // count saturates once the header is in
          if (q.byte_cnt != `EF_HDR_BYTES) begin
            d.byte_cnt = q.byte_cnt + 4'h1;
          end
          if (rx_last_i) begin
            d.done = 1'b1;
            d.copy = keep;
            d.mc_hit = mc_hit & hdr_ok;
            d.uc_hit = uc_hit & hdr_ok;
            d.pause_drop = is_pause & q.cfg[`EF_CFG_NO_PAUSE] & hdr_ok;
            d.last_idx = hash_idx;
            d.rx_st = eth_filt_pkg::RX_IDLE;
          end
        end
      end
      default: begin
        d.rx_st = eth_filt_pkg::RX_IDLE;
      end
    endcase

    // transmit size counter, wraps after all ones
    if (tx_counts) begin
      d.tx_cnt = q.tx_cnt + 32'h0000_0001;
    end

    // write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end

    // write completes once both halves are held
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(q.awaddr) ? `EF_RESP_OKAY : `EF_RESP_SLVERR;
      case (q.awaddr)
        `EF_OFF_NET_CFG: d.cfg = merge(q.cfg, q.wdata, q.wstrb);
        `EF_OFF_HASH_LO: d.hash_lo = merge(q.hash_lo, q.wdata, q.wstrb);
        `EF_OFF_HASH_HI: d.hash_hi = merge(q.hash_hi, q.wdata, q.wstrb);
        `EF_OFF_SA1_LO: d.sa_lo = merge(q.sa_lo, q.wdata, q.wstrb);
        `EF_OFF_SA1_HI: d.sa_hi = merge(q.sa_hi, q.wdata, q.wstrb);
        `EF_OFF_TID1: d.tid = merge(q.tid, q.wdata, q.wstrb);
        // counter and status ignore writes
        default: begin
          d.cfg = q.cfg;
        end
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // read answer is registered, one cycle after the address
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = rd_word(q, s_axi_araddr);
      d.rresp = is_mapped(s_axi_araddr) ? `EF_RESP_OKAY : `EF_RESP_SLVERR;
    end
  end

  // all registers reset to zero, the counter included
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // eth_rx_address_filter

// >>> tb/eth_rx_address_filter_properties.sv
// port-level assertions of the receive address filter
`timescale 1ns/1ps
module eth_rx_address_filter_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // byte stream and buffer
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire logic mem_valid_o,
  input wire logic [7:0] mem_data_o,
  input wire logic mem_last_o,
  input wire logic mem_ready_i,
  // verdict
  input wire logic frame_done_o,
  input wire logic frame_copy_o,
  input wire logic frame_mc_hit_o,
  input wire logic frame_uc_hit_o,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rready
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // verdict timing: one pulse, one edge after the last byte, flags held between frames
  chk_done_pulse: assert property (frame_done_o |=> !frame_done_o) else $error("done too long");
  chk_done_late: assert property (rx_valid_i && rx_ready_o && rx_last_i
    |=> frame_done_o) else $error("no done after last byte");
  chk_verdict_hold: assert property (!frame_done_o |->
    $stable({frame_copy_o, frame_mc_hit_o, frame_uc_hit_o})) else $error("verdict moved");
  // a frame is either group or individual, never both
  chk_hit_excl: assert property (!(frame_mc_hit_o && frame_uc_hit_o))
    else $error("both hits");
  // the buffer only refuses when it holds something
  chk_ready_full: assert property (!rx_ready_o |-> mem_valid_o) else $error("refused empty");
  chk_mem_hold: assert property (mem_valid_o && !mem_ready_i |=>
    mem_valid_o && $stable({mem_data_o, mem_last_o})) else $error("head moved");
  // bus answers and their holding
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("late write answer");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
endmodule // eth_rx_address_filter_properties

bind eth_rx_address_filter eth_rx_address_filter_properties u_chk (.clock_i, .rst_b_i,
  .rx_valid_i, .rx_last_i, .rx_ready_o, .mem_valid_o, .mem_data_o, .mem_last_o, .mem_ready_i,
  .frame_done_o, .frame_copy_o, .frame_mc_hit_o, .frame_uc_hit_o, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rready);

// >>> tb/phy_model.sv
// behavioural line side feeding received frames byte by byte
`timescale 1ns/1ps
module phy_model (
  // clock
  input wire logic clock_i,
  // byte stream
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  output logic [2:0] rx_stat_o,
  input wire logic rx_ready_i,
  // error pin
  output logic rx_err_o
);
  logic [7:0] fb [0:19];
  logic [7:0] byte_q = 8'h00;
  logic [7:0] idle_q = 8'h5a;
  initial begin
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_stat_o = 3'h0;
    rx_err_o = 1'b0;
  end
  // idle bytes keep changing so a stale byte never passes for data
  always @(posedge clock_i) idle_q <= idle_q + 8'h35;
  assign rx_data_o = rx_valid_o ? byte_q : idle_q;
  // st: long, short, bad fcs with the last byte; st[3] raises the error pin mid-frame
  task automatic send(input int n, input logic [3:0] st);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      @(posedge clock_i);
      rx_valid_o <= 1'b1;
      byte_q <= fb[i];
      rx_last_o <= (i == n - 1);
      rx_stat_o <= (i == n - 1) ? st[2:0] : 3'h0;
      rx_err_o <= st[3] && i > 1;
      k = 0;
      @(negedge clock_i);
      while (!rx_ready_i && k < 200) begin
        @(negedge clock_i);
        k++;
      end
    end
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_stat_o <= 3'h0;
    rx_err_o <= 1'b0;
  endtask
endmodule // phy_model

// >>> tb/eth_rx_address_filter_tb_top.sv
// self-checking bench of the receive address filter
`timescale 1ns/1ps
`include "eth_filt_consts.svh"
module eth_rx_address_filter_tb_top;
  localparam logic [31:0] cp = 32'h1 << `EF_CFG_COPY_ALL;
  localparam logic [31:0] mc = 32'h1 << `EF_CFG_MC_HASH;
  localparam logic [31:0] uc = 32'h1 << `EF_CFG_UC_HASH;
  localparam logic [31:0] np = 32'h1 << `EF_CFG_NO_PAUSE;
  localparam logic [31:0] kf = 32'h1 << `EF_CFG_KEEP_FCS;
  localparam logic [1:0] ok = `EF_RESP_OKAY;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic rx_valid_i, rx_last_i, rx_too_long_i, rx_too_short_i, rx_fcs_bad_i, receive_error_input_i;
  logic [7:0] rx_data_i, mem_data_o;
  logic rx_ready_o, mem_valid_o, mem_last_o, frame_done_o, frame_copy_o, frame_mc_hit_o;
  logic frame_uc_hit_o, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_ready_i = 1'b1;
  logic tx_done_i = 1'b0, tx_underrun_i = 1'b0, tx_retry_limit_i = 1'b0;
  logic [13:0] tx_len_i = 14'h0000;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count = 0;
  int n_compared = 0;
  // 125 MHz
  always #4 clock_i = ~clock_i;
  phy_model phy (.clock_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_last_o(rx_last_i),
    .rx_stat_o({rx_fcs_bad_i, rx_too_short_i, rx_too_long_i}), .rx_ready_i(rx_ready_o),
    .rx_err_o(receive_error_input_i));
  eth_rx_address_filter DUT (.clock_i, .rst_b_i, .rx_valid_i, .rx_data_i, .rx_last_i,
    .rx_too_long_i, .rx_too_short_i, .rx_fcs_bad_i, .rx_ready_o, .receive_error_input_i,
    .mem_valid_o, .mem_data_o, .mem_last_o, .mem_ready_i, .frame_done_o, .frame_copy_o,
    .frame_mc_hit_o, .frame_uc_hit_o, .tx_done_i, .tx_len_i, .tx_underrun_i, .tx_retry_limit_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic summarize;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a wait that runs out ends the run
  task automatic tmo(input string nm);
    chk(nm, 32'h1, 32'h0);
    summarize();
  endtask
  // own reference of the address hash, kept apart from the design's
  function automatic logic [5:0] hidx(input logic [47:0] d);
    hidx = 6'h00;
    for (int n = 0; n < 48; n++) hidx[n % 6] ^= d[n];
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, gb;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clock_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid;
      if (gb) chk("bresp", 32'(er), 32'(s_axi_bresp));
      @(posedge clock_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (gb) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    tmo("write");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, gr;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge clock_i);
      ta = s_axi_arvalid && s_axi_arready;
      gr = s_axi_rvalid;
      if (gr) chk("rdata", ed, s_axi_rdata);
      if (gr) chk("rresp", 32'(er), 32'(s_axi_rresp));
      @(posedge clock_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (gr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    tmo("read");
  endtask
  task automatic tbl(input logic [63:0] t, input logic [31:0] c);
    wr(`EF_OFF_HASH_LO, t[31:0], ok);
    wr(`EF_OFF_HASH_HI, t[63:32], ok);
    wr(`EF_OFF_NET_CFG, c, ok);
  endtask
  // ex and mk: copy, multicast hit, unicast hit
  task automatic frm(input logic [47:0] da, input logic [15:0] ty, input logic [3:0] st,
                     input logic [2:0] ex, input logic [2:0] mk);
    int k;
    for (k = 0; k < 20; k++) phy.fb[k] = 8'(k);
    for (k = 0; k < 6; k++) phy.fb[k] = da[8*k +: 8];
    phy.fb[12] = ty[15:8];
    phy.fb[13] = ty[7:0];
    phy.send(20, st);
    for (k = 0; k < 20; k++) begin
      @(negedge clock_i);
      if (frame_done_o === 1'b1) break;
    end
    if (k == 20) tmo("done");
    chk("verdict", 32'(ex & mk), 32'({frame_copy_o, frame_mc_hit_o, frame_uc_hit_o} & mk));
  endtask
  task automatic s_regs;
    rd(`EF_OFF_TX_512, 32'h0, ok);
    rd(12'h200, 32'h0, `EF_RESP_SLVERR);
    wr(12'h200, 32'h1, `EF_RESP_SLVERR);
    wr(`EF_OFF_HASH_HI, 32'h89ab_cdef, ok);
    rd(`EF_OFF_HASH_HI, 32'h89ab_cdef, ok);
  endtask
  task automatic s_hash;
    logic [47:0] das [0:3] = '{48'h1, 48'h8000_0000_0001, 48'h0400_0000_0000, 48'h20};
    logic [63:0] t;
    for (int k = 0; k < 4; k++) begin
      t = 64'h1 << hidx(das[k]);
      tbl(t, mc | uc);
      frm(das[k], 16'h0800, 4'h0, {1'b1, das[k][0], !das[k][0]}, 3'h7);
      tbl(t, das[k][0] ? uc : mc);
      frm(das[k], 16'h0800, 4'h0, 3'h0, 3'h7);
      tbl(~t, mc | uc);
      frm(das[k], 16'h0800, 4'h0, 3'h0, 3'h7);
    end
    tbl({64{1'b1}}, mc);
    frm(48'h1234_5678_9abb, 16'h0800, 4'h0, 3'h6, 3'h7);
  endtask
  task automatic s_copy;
    logic [3:0] sts [0:4] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    tbl(64'h0, cp);
    for (int k = 0; k < 5; k++) begin
      frm(48'ha02, 16'h0800, sts[k], {sts[k] == 4'h0, 2'h0}, 3'h7);
    end
    tbl(64'h0, cp | kf);
    frm(48'ha02, 16'h0800, 4'h4, 3'h4, 3'h7);
    frm(48'ha02, 16'h0800, 4'h1, 3'h0, 3'h7);
  endtask
  task automatic s_pause;
    tbl({64{1'b1}}, cp | np | mc);
    frm(48'h1, `EF_PAUSE_TYPE, 4'h0, 3'h0, 3'h4);
    tbl({64{1'b1}}, cp | mc);
    frm(48'h1, `EF_PAUSE_TYPE, 4'h0, 3'h4, 3'h4);
    wr(`EF_OFF_TID1, 32'h8000_8808, ok);
    wr(`EF_OFF_SA1_LO, 32'h0000_0a02, ok);
    tbl(64'h0, np);
    frm(48'ha02, `EF_PAUSE_TYPE, 4'h0, 3'h0, 3'h4);
    tbl(64'h0, 32'h0);
    frm(48'ha02, `EF_PAUSE_TYPE, 4'h0, 3'h4, 3'h4);
    // status keeps the index of the last frame: kept, no hash hit, not a dropped pause
    rd(`EF_OFF_RX_STAT, {18'h0, hidx(48'ha02), 8'h02}, ok);
  endtask
  task automatic s_tx;
    // underrun, retry limit, length
    logic [15:0] ev [0:6] = '{16'h01ff, 16'h0200, 16'h03ff, 16'h0400,
                              16'h82bc, 16'h42bc, 16'h0320};
    for (int k = 0; k < 7; k++) begin
      @(posedge clock_i);
      tx_done_i <= 1'b1;
      tx_len_i <= ev[k][13:0];
      tx_underrun_i <= ev[k][15];
      tx_retry_limit_i <= ev[k][14];
    end
    @(posedge clock_i);
    tx_done_i <= 1'b0;
    tx_underrun_i <= 1'b0;
    tx_retry_limit_i <= 1'b0;
    rd(`EF_OFF_TX_512, 32'h3, ok);
    wr(`EF_OFF_TX_512, 32'h0, ok);
    rd(`EF_OFF_TX_512, 32'h3, ok);
  endtask
  task automatic s_stall;
    int k;
    int n;
    for (k = 0; k < 20; k++) phy.fb[k] = 8'(8'ha0 + k);
    @(posedge clock_i);
    mem_ready_i <= 1'b0;
    fork
      phy.send(20, 4'h0);
    join_none
    for (k = 0; k < 30 && rx_ready_o !== 1'b0; k++) @(negedge clock_i);
    repeat (5) @(negedge clock_i);
    chk("ready_full", 32'h0, 32'(rx_ready_o));
    chk("head", 32'ha0, 32'(mem_data_o));
    @(posedge clock_i);
    mem_ready_i <= 1'b1;
    n = 0;
    for (k = 0; k < 200 && n < 20; k++) begin
      @(negedge clock_i);
      if (mem_valid_o && mem_ready_i) begin
        chk("mem_byte", 32'(8'ha0 + n), 32'(mem_data_o));
        chk("mem_last", 32'(n == 19), 32'(mem_last_o));
        n++;
      end
    end
    if (n < 20) tmo("drain");
    // the last byte leaves the buffer at the edge after it was seen
    @(negedge clock_i);
    chk("empty", 32'h0, 32'(mem_valid_o));
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    s_regs();
    s_hash();
    s_copy();
    s_pause();
    s_tx();
    s_stall();
    summarize();
  end
endmodule // eth_rx_address_filter_tb_top
